/* core/mdr_regs.sv */
// Control and fault register bank of a small H-bridge motor driver.
// Function
// - Control register at 0x00, resets to zero.
// - Fault register at 0x01, resets to zero.
// - Control bits 7..2 drive the DAC code.
// - Control bits 1..0 select the bridge state.
// - Writing one to fault bit 7 clears faults.
// - Fault bit 4 flags prolonged current limit.
// - Fault bit 3 flags overtemperature.
// - Fault bit 2 flags supply undervoltage.
// - Fault bit 1 flags overcurrent shutdown.
// - Fault bit 0 summarises any fault present.
// - Both select bits zero: sleep, outputs released.
// - Any select bit set: wake, bridge enabled.
// - Leaving sleep pulses the error pin low.
// - Sense comparator above threshold feeds current limit.
// - Undervoltage may resample the slave address.
// - Select decode: coast, forward, reverse, brake.
// - Reads return the last selected subaddress.
// - Slave address is base plus latched pin code.
// - Overcurrent keeps bridge off until cleared.
`timescale 1ns/100ps
`include "mdr_params.svh"
module mdr_regs
   import mdr_pkg::*;
#(
   parameter int WAKE_CYCLES = `MDR_WAKE_CYCLES,
   parameter int ILIM_HOLD   = `MDR_ILIM_HOLD
) (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       subAddrWrite,
   input  wire logic [7:0] subAddrData,
   input  wire logic       regWrite,
   input  wire logic [7:0] regWriteData,
   input  wire logic       regRead,
   output logic      [7:0] regReadData,
   output logic            regReadValid,
   input  wire logic       currentSensePin,
   input  wire logic       overTempPin,
   input  wire logic       supplyLowPin,
   input  wire logic       overcurrentPin,
   input  wire logic [3:0] addrPinCode,
   output logic      [6:0] slaveAddr,
   output logic      [5:0] driveVoltageCode,
   output logic            sleepMode,
   output logic            motorOutA,
   output logic            motorOutAOeN,
   output logic            motorOutB,
   output logic            motorOutBOeN,
   output logic            errorPinOut,
   output logic            errorPinOeN
);

   // Counter widths follow the parameters, so a longer pulse or hold time
   // needs no edit below.
   // Width of the wake pulse counter, wide enough for the pulse length.
   localparam int WCW = $clog2(WAKE_CYCLES + 1);
   // Width of the current-limit persistence counter.
   localparam int ICW = $clog2(ILIM_HOLD + 1);

   // Synchronised pin levels; all of them come from outside the clock domain.
   logic       senseSync;              // Sense voltage above the limit threshold.
   logic       otsSync;                // Die too hot.
   logic       uvloSync;               // Supply below lockout level.
   logic       ocpSync;                // Analog limit persisted past the shutdown time.
   logic [3:0] addrSync;               // Address code synchronised from the pins.

   // Register state.
   logic [7:0] subAddr_reg;            // Subaddress selected by the master.
   logic [7:0] ctrl_reg;               // Control register.
   logic [7:0] ctrl_next;
   logic       ilim_reg;               // Latched current-limit fault.
   logic       ilim_next;
   logic       ots_reg;                // Latched overtemperature fault.
   logic       ots_next;
   logic       supply_low_flag_reg;               // Latched undervoltage fault.
   logic       supply_low_flag_next;
   logic       ocp_reg;                // Latched overcurrent fault.
   logic       ocp_next;
   logic       uvloPrev_reg;           // Last undervoltage level, for edge detection.
   logic [ICW-1:0] ilimCnt_reg;        // Cycles the sense comparator has been high.
   logic [WCW-1:0] wakeCnt_reg;        // Remaining cycles of the wake pulse.
   logic [1:0] addrWait_reg;           // Settling delay before the address capture.
   mdr_pwr_e   pwr_reg;                // Power sequencing state.
   mdr_pwr_e   pwr_next;

   // Decoded strobes and levels.
   // The pointer picks the register; only the two mapped subaddresses respond.
   wire        selCtrl    = (subAddr_reg == `MDR_CTRL_ADDR);
   wire        selFault   = (subAddr_reg == `MDR_FAULT_ADDR);
   wire        ctrlWrite  = regWrite && selCtrl;
   wire        faultWrite = regWrite && selFault;
   wire        clearHit   = faultWrite && regWriteData[`MDR_CLEAR_BIT];
   wire [1:0]  selBits    = ctrl_reg[`MDR_SEL_B_BIT:`MDR_SEL_A_BIT];
   wire        wantSleep  = (selBits == 2'b00);
   wire        ilimEvent  = senseSync && (ilimCnt_reg == ICW'(ILIM_HOLD - 1));
   wire        uvloRise   = uvloSync && !uvloPrev_reg;
   // The address is taken once when the pins have settled after reset, and
   // again on every undervoltage onset.
   wire        addrLoad   = (addrWait_reg == `MDR_ADDR_SETTLE) || uvloRise;
   // The summary bit also follows the live temperature and supply levels, so
   // it drops by itself once those recover and nothing is latched.
   wire        anyFault   = ilim_reg || ots_reg || supply_low_flag_reg || ocp_reg
                            || otsSync || uvloSync;
   // A live temperature or supply fault turns the bridge off; latched overcurrent keeps it off until
   // the host writes the clear bit, latched current limit until a clear or sleep.
   wire        bridgeOk   = (pwr_reg != PWR_SLEEP) && !ocp_reg && !ilim_reg
                            && !otsSync && !uvloSync;
   wire        wakeActive = (wakeCnt_reg != '0);
   wire [7:0]  faultView;
   wire [7:0]  readMux;

   // Read view of the fault register: clear bit and unused bits read zero.
   assign faultView = {1'b0, 2'b00, ilim_reg, ots_reg, supply_low_flag_reg, ocp_reg, anyFault};

   // Unmapped subaddresses read as zero.
   assign readMux = selCtrl  ? ctrl_reg  :
                    selFault ? faultView : 8'h00;

   // The fault pins and address code arrive asynchronously.
   mdr_sync #(
      .WIDTH (8)
   ) u_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .asyncIn ({currentSensePin, overTempPin, supplyLowPin, overcurrentPin, addrPinCode}),
      .syncOut ({senseSync, otsSync, uvloSync, ocpSync, addrSync})
   );

   // Combinational next values for the registers.
   always_comb begin
      // The control register takes a whole byte; every bit is writable.
      ctrl_next = ctrlWrite ? regWriteData : ctrl_reg;
      // Each source bit is sticky; a new event wins over a clear in the same cycle.
      ilim_next = ilimEvent || (ilim_reg && !clearHit && !wantSleep);
      ots_next  = otsSync   || (ots_reg  && !clearHit);
      supply_low_flag_next = uvloSync  || (supply_low_flag_reg && !clearHit);
      ocp_next  = ocpSync   || (ocp_reg  && !clearHit);
   end

   // Power state sequencing follows the select bits.
   // The wake state lets the error pin pulse and the bridge enable start
   // together; the run state is entered only once the pulse has run out.
   always_comb begin
      pwr_next = pwr_reg;
      unique case (pwr_reg)
         PWR_SLEEP: begin
            // Any select bit set wakes the bridge.
            if (!wantSleep) begin
               pwr_next = PWR_WAKE;
            end
         end
         PWR_WAKE: begin
            // Hold here while the wake pulse is on the error pin.
            if (wantSleep) begin
               pwr_next = PWR_SLEEP;
            end else if (wakeCnt_reg == WCW'(1)) begin
               pwr_next = PWR_RUN;
            end
         end
         PWR_RUN: begin
            // Clearing both select bits goes back to sleep.
            if (wantSleep) begin
               pwr_next = PWR_SLEEP;
            end
         end
         default: begin
            // The unused code recovers into sleep, the safe state.
            pwr_next = PWR_SLEEP;
         end
      endcase
   end

   // Subaddress pointer; every read uses the last one written.
   // It resets to the control register so a read straight after reset answers.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         subAddr_reg <= `MDR_CTRL_ADDR;
      end else if (subAddrWrite) begin
         subAddr_reg <= subAddrData;
      end
   end

   // Control and fault registers.
   // Faults latch here. Only the clear bit, and sleep for the current limit,
   // remove them; the source bits themselves ignore write data.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ctrl_reg <= `MDR_CTRL_RST;
         ilim_reg <= 1'b0;
         ots_reg  <= 1'b0;
         supply_low_flag_reg <= 1'b0;
         ocp_reg  <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         ilim_reg <= ilim_next;
         ots_reg  <= ots_next;
         supply_low_flag_reg <= supply_low_flag_next;
         ocp_reg  <= ocp_next;
      end
   end

   // Current-limit persistence: a short spike from motor start does not trip.
   // The count freezes at its end value while the comparator stays high, so the
   // event keeps firing and a clear cannot release the flag under a standing limit.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ilimCnt_reg <= '0;
      end else if (!senseSync || wantSleep) begin
         ilimCnt_reg <= '0;
      end else if (!ilimEvent) begin
         ilimCnt_reg <= ilimCnt_reg + ICW'(1);
      end
   end

   // Power state and the wake pulse counter.
   // A return to sleep in the middle of the pulse cuts it short, so the next
   // wake starts a fresh full pulse.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pwr_reg     <= PWR_SLEEP;
         wakeCnt_reg <= '0;
      end else begin
         pwr_reg <= pwr_next;
         if (pwr_reg == PWR_SLEEP && pwr_next == PWR_WAKE) begin
            wakeCnt_reg <= WCW'(WAKE_CYCLES);
         end else if (pwr_next == PWR_SLEEP) begin
            wakeCnt_reg <= '0;
         end else if (wakeActive) begin
            wakeCnt_reg <= wakeCnt_reg - WCW'(1);
         end
      end
   end

   // Slave address capture. The pins are latched once after reset, when the
   // synchroniser has settled; an undervoltage edge takes them again, which
   // may leave the bus silent if the pins have moved meanwhile.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         addrWait_reg <= 2'b00;
         uvloPrev_reg <= 1'b0;
         slaveAddr    <= `MDR_ADDR_BASE;
      end else begin
         uvloPrev_reg <= uvloSync;
         // The settle counter stops at its top value so the capture happens once.
         if (addrWait_reg != '1) begin
            addrWait_reg <= addrWait_reg + 2'h1;
         end
         if (addrLoad) begin
            slaveAddr <= `MDR_ADDR_BASE + {3'b000, addrSync};
         end
      end
   end

   // Read data register and its one-cycle valid strobe.
   // Reads use the pointer as it stood before this edge, so a pointer write and
   // a read in one cycle still answer for the old subaddress.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         regReadData  <= 8'h00;
         regReadValid <= 1'b0;
      end else begin
         regReadValid <= regRead;
         if (regRead) begin
            regReadData <= readMux;
         end
      end
   end

   // DAC code and sleep flag outputs, registered from the control byte.
   // The code is taken from the next value, so the DAC and the read-back
   // change at the same edge.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         driveVoltageCode <= 6'h00;
         sleepMode        <= 1'b1;
      end else begin
         driveVoltageCode <= ctrl_next[`MDR_CODE_MSB:`MDR_CODE_LSB];
         sleepMode        <= (pwr_next == PWR_SLEEP);
      end
   end

   // Bridge outputs. Enables are active low; a disabled or sleeping bridge
   // releases both outputs to high impedance. Register updates reach the
   // pins one cycle after the write, two when the write wakes the bridge from sleep, with the fault gating from this cycle.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         motorOutA    <= 1'b0;
         motorOutB    <= 1'b0;
         motorOutAOeN <= 1'b1;
         motorOutBOeN <= 1'b1;
      end else if (!bridgeOk) begin
         motorOutA    <= 1'b0;
         motorOutB    <= 1'b0;
         motorOutAOeN <= 1'b1;
         motorOutBOeN <= 1'b1;
      end else begin
         unique case (mdr_bridge_e'(selBits))
            BR_COAST: begin
               // Both outputs released; the motor coasts.
               motorOutA    <= 1'b0;
               motorOutB    <= 1'b0;
               motorOutAOeN <= 1'b1;
               motorOutBOeN <= 1'b1;
            end
            BR_FORWARD: begin
               // First output high, second low.
               motorOutA    <= 1'b1;
               motorOutB    <= 1'b0;
               motorOutAOeN <= 1'b0;
               motorOutBOeN <= 1'b0;
            end
            BR_REVERSE: begin
               // Second output high, first low.
               motorOutA    <= 1'b0;
               motorOutB    <= 1'b1;
               motorOutAOeN <= 1'b0;
               motorOutBOeN <= 1'b0;
            end
            BR_BRAKE: begin
               // Both outputs high; the winding is shorted and the motor brakes.
               motorOutA    <= 1'b1;
               motorOutB    <= 1'b1;
               motorOutAOeN <= 1'b0;
               motorOutBOeN <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain error pin: pulled low while a fault stands or during the
   // wake pulse. The output level is always zero; only the enable moves.
   // Releasing the pin lets an outside pull-up take it high; never driving it
   // high is what lets several devices share one fault line.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         errorPinOut <= 1'b0;
         errorPinOeN <= 1'b1;
      end else begin
         errorPinOut <= 1'b0;
         errorPinOeN <= !(anyFault || wakeActive);
      end
   end

endmodule : mdr_regs

/* core/mdr_params.svh */
// Constant definitions for the motor driver control and fault register bank.
`ifndef MDR_PARAMS_SVH
`define MDR_PARAMS_SVH

// Register subaddresses.
`define MDR_CTRL_ADDR       8'h00
`define MDR_FAULT_ADDR      8'h01

// Reset values.
`define MDR_CTRL_RST        8'h00
`define MDR_FAULT_RST       8'h00

// Control register field positions.
`define MDR_CODE_MSB        7
`define MDR_CODE_LSB        2
`define MDR_SEL_B_BIT       1
`define MDR_SEL_A_BIT       0

// Fault register field positions.
`define MDR_CLEAR_BIT       7
`define MDR_ILIM_BIT        4
`define MDR_OTS_BIT         3
`define MDR_SUPPLY_LOW_FLAG_BIT        2
`define MDR_OCP_BIT         1
`define MDR_ANY_BIT         0

// Seven-bit slave address base, the 8-bit write address C0h shifted right.
`define MDR_ADDR_BASE       7'h60

// Timing: clock period and the low pulse on the error pin after wake.
`define MDR_CLK_PERIOD_NS   10
`define MDR_WAKE_PULSE_NS   1000
`define MDR_WAKE_CYCLES     (`MDR_WAKE_PULSE_NS / `MDR_CLK_PERIOD_NS)

// Cycles the sense comparator must stay high to count as a current-limit fault.
`define MDR_ILIM_HOLD       16

// Edges after reset release after which the address pins are first captured; the
// synchroniser needs two of them to carry the pin levels through.
`define MDR_ADDR_SETTLE     2'h2

`endif

/* core/mdr_pkg.sv */
// Types shared by the motor driver register bank.
package mdr_pkg;

   // Power sequencing states of the bridge.
   typedef enum logic [1:0] {
      PWR_SLEEP = 2'b00,
      PWR_WAKE  = 2'b01,
      PWR_RUN   = 2'b10
   } mdr_pwr_e;

   // Bridge functions decoded from the two select bits {b, a}.
   typedef enum logic [1:0] {
      BR_COAST   = 2'b00,
      BR_FORWARD = 2'b01,
      BR_REVERSE = 2'b10,
      BR_BRAKE   = 2'b11
   } mdr_bridge_e;

endpackage : mdr_pkg

/* core/mdr_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/100ps
module mdr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_reg;   // First stage, read only by the second stage.

   // Both stages clear on reset so no stale level leaks out after release.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         meta_reg <= '0;
         syncOut  <= '0;
      end else begin
         meta_reg <= asyncIn;
         syncOut  <= meta_reg;
      end
   end

endmodule : mdr_sync

/* dv/mdr_regs_properties.sv */
// Concurrent checks on the ports of the motor driver register bank.
`timescale 1ns/100ps
module mdr_regs_checker #(
   parameter int WAKE_CYCLES = 100,
   parameter int ILIM_HOLD   = 16
) (
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic       subAddrWrite,
   input wire logic [7:0] subAddrData,
   input wire logic       regWrite,
   input wire logic [7:0] regWriteData,
   input wire logic       regRead,
   input wire logic [7:0] regReadData,
   input wire logic       regReadValid,
   input wire logic [5:0] driveVoltageCode,
   input wire logic       sleepMode,
   input wire logic       motorOutA,
   input wire logic       motorOutAOeN,
   input wire logic       motorOutB,
   input wire logic       motorOutBOeN,
   input wire logic       errorPinOeN
);
   logic [7:0] selReg;   // Shadow of the selected subaddress.
   logic [7:0] rdSelReg; // Subaddress that the pending read answers for.
   logic [7:0] ctrlReg;  // Shadow of the last control write.
   logic [15:0] wakeAge; // Cycles since the block last left sleep, saturating.

   // Shadows follow the host side only, so a slip inside the block cannot hide here.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         selReg   <= 8'h00;
         rdSelReg <= 8'h00;
         ctrlReg  <= 8'h00;
      end else begin
         if (subAddrWrite) selReg <= subAddrData;
         if (regRead) rdSelReg <= selReg;
         if (regWrite && selReg == 8'h00) ctrlReg <= regWriteData;
      end
   end

   // Age of the current awake spell; it restarts whenever sleep is shown.
   always_ff @(posedge ref_clk) begin
      if (!resetn || sleepMode) begin
         wakeAge <= 16'h0000;
      end else if (wakeAge != 16'hFFFF) begin
         wakeAge <= wakeAge + 16'h0001;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Leaving sleep must be followed closely by the low pulse on the error pin.
   sequence wakeSeq;
      $fell(sleepMode) ##[0:2] !errorPinOeN;
   endsequence
   // The decode is only judged once the control value has settled.
   sequence settledSeq;
      $stable(ctrlReg)[*4] ##0 !motorOutAOeN;
   endsequence

   read_answer_a: assert property (regRead |=> regReadValid)
      else $error("read request got no answer");
   valid_cause_a: assert property (regReadValid |-> $past(regRead))
      else $error("read answer without request");
   code_follow_a: assert property ((regWrite && selReg == 8'h00)
      |=> driveVoltageCode == $past(regWriteData[7:2])) else $error("drive code wrong");
   sleep_enter_a: assert property ((regWrite && selReg == 8'h00
      && regWriteData[1:0] == 2'b00) |-> ##[1:3] sleepMode) else $error("sleep not entered");
   sleep_float_a: assert property ($rose(sleepMode)
      |-> ##[0:1] (motorOutAOeN && motorOutBOeN)) else $error("outputs driven in sleep");
   wake_pulse_a: assert property ($fell(sleepMode) |-> wakeSeq)
      else $error("no wake pulse");
   wake_length_a: assert property ((wakeAge != 16'h0000 && wakeAge <= 16'(WAKE_CYCLES))
      |-> !errorPinOeN) else $error("wake pulse too short");
   drive_decode_a: assert property (settledSeq |-> {motorOutB, motorOutA} == ctrlReg[1:0])
      else $error("bridge decode wrong");
   fault_view_a: assert property ((regReadValid && rdSelReg == 8'h01)
      |-> regReadData[7:5] == 3'b000 && (regReadData[4:1] == 4'h0 || regReadData[0]))
      else $error("fault view malformed");
   unmapped_read_a: assert property ((regReadValid && rdSelReg > 8'h01)
      |-> regReadData == 8'h00) else $error("unmapped read not zero");
endmodule : mdr_regs_checker

bind mdr_regs mdr_regs_checker #(.WAKE_CYCLES(WAKE_CYCLES), .ILIM_HOLD(ILIM_HOLD))
   mdr_regs_checker_inst (.ref_clk, .resetn, .subAddrWrite, .subAddrData, .regWrite,
   .regWriteData, .regRead, .regReadData, .regReadValid, .driveVoltageCode, .sleepMode,
   .motorOutA, .motorOutAOeN, .motorOutB, .motorOutBOeN, .errorPinOeN);

/* dv/mdr_host_model.sv */
// Behavioural serial-bus master that reaches the register bank byte by byte.
`timescale 1ns/100ps
module mdr_host_model (
   input  wire logic       ref_clk,
   output logic            subAddrWrite,
   output logic      [7:0] subAddrData,
   output logic            regWrite,
   output logic      [7:0] regWriteData,
   output logic            regRead
);
   // Idle at time zero; data lines are never left at a stale value.
   initial begin
      subAddrWrite = 1'b0;
      subAddrData  = 8'h00;
      regWrite     = 1'b0;
      regWriteData = 8'h00;
      regRead      = 1'b0;
   end

   // Select a subaddress; released data shows the inverse of the last byte.
   task automatic sel(input logic [7:0] a);
      @(negedge ref_clk);
      subAddrWrite = 1'b1;
      subAddrData  = a;
      @(negedge ref_clk);
      subAddrWrite = 1'b0;
      subAddrData  = ~a;
   endtask : sel

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sel(a);
      regWrite     = 1'b1;
      regWriteData = d;
      @(negedge ref_clk);
      regWrite     = 1'b0;
      regWriteData = ~d;
   endtask : wr

   // A read always follows its own subaddress write.
   task automatic rd(input logic [7:0] a);
      sel(a);
      regRead = 1'b1;
      @(negedge ref_clk);
      regRead = 1'b0;
   endtask : rd

   // Park the bridge before supply removal.
   task automatic park;
      wr(8'h00, 8'h00);
   endtask : park
endmodule : mdr_host_model

/* dv/mdr_regs_tb.sv */
// Self-checking bench for the motor driver register bank.
`timescale 1ns/100ps
`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failCount++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module mdr_regs_tb;
   localparam int WAKE = 8; // Shortened wake pulse.
   localparam int HOLD = 3; // Shortened current-limit persistence.
   logic       ref_clk, resetn, subAddrWrite, regWrite, regRead, regReadValid;
   logic [7:0] subAddrData, regWriteData, regReadData, ctrl, expData;
   logic       sleepMode, motorOutA, motorOutAOeN, motorOutB, motorOutBOeN;
   logic       errorPinOut, errorPinOeN;
   logic [3:0] faultPins, addrPinCode; // Pins: sense, temperature, supply, overcurrent.
   logic [6:0] slaveAddr;
   logic [5:0] driveVoltageCode;
   logic [1:0] sel2;
   logic [7:0] expQ[$];                // Expected read bytes, oldest first.
   logic [7:0] expFault[4] = '{8'h11, 8'h09, 8'h05, 8'h03};
   int         failCount, comparisons, cycles, seed;

   mdr_regs #(.WAKE_CYCLES(WAKE), .ILIM_HOLD(HOLD)) mdr_regs_inst (.ref_clk, .resetn,
      .subAddrWrite, .subAddrData, .regWrite, .regWriteData, .regRead, .regReadData,
      .regReadValid, .currentSensePin(faultPins[0]), .overTempPin(faultPins[1]),
      .supplyLowPin(faultPins[2]), .overcurrentPin(faultPins[3]), .addrPinCode, .slaveAddr,
      .driveVoltageCode, .sleepMode, .motorOutA, .motorOutAOeN, .motorOutB, .motorOutBOeN,
      .errorPinOut, .errorPinOeN);
   mdr_host_model mdr_host_model_inst (.ref_clk, .subAddrWrite, .subAddrData, .regWrite,
      .regWriteData, .regRead);

   // Free-running 100 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Each answer is matched against the oldest note; a stray answer is a mismatch too.
   // Sampled mid-cycle, where the registered answer has settled.
   always @(negedge ref_clk) begin
      if (regReadValid === 1'b1) begin
         expData = (expQ.size() != 0) ? expQ.pop_front() : 8'hXX;
         `CHECK("read data", expData, regReadData)
      end
   end

   // Hang guard, far above the few hundred cycles the sequence needs.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failCount++;
         stopTest();
      end
   end

   task automatic stopTest;
      $display("comparisons %0d mismatches %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stopTest

   task automatic readExp(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      mdr_host_model_inst.rd(a);
   endtask : readExp

   initial begin
      seed        = 87;
      resetn      = 1'b0;
      faultPins   = 4'h0;
      addrPinCode = 4'($unsigned($random(seed)) % 9);
      repeat (6) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (4) @(negedge ref_clk);
      `CHECK("slave address", 7'h60 + 7'(addrPinCode), slaveAddr)
      `CHECK("sleep at start", 1'b1, sleepMode)
      `CHECK("error level", 1'b0, errorPinOut)
      readExp(8'h00, 8'h00);
      readExp(8'h01, 8'h00);
      $display("reset test done");
      // Walk forward, reverse, brake and coast with random drive codes.
      for (int i = 0; i < 4; i++) begin
         sel2 = 2'(i + 1);
         ctrl = {6'($random(seed)), sel2};
         mdr_host_model_inst.wr(8'h00, ctrl);
         repeat (4) @(negedge ref_clk);
         if (i == 0) begin
            `CHECK("wake pulse", 1'b0, errorPinOeN)
            repeat (WAKE + 4) @(negedge ref_clk);
            `CHECK("pulse end", 1'b1, errorPinOeN)
         end
         `CHECK("drive code", ctrl[7:2], driveVoltageCode)
         `CHECK("sleep", sel2 == 2'b00, sleepMode)
         `CHECK("enables", {2{sel2 == 2'b00}}, {motorOutBOeN, motorOutAOeN})
         if (sel2 != 2'b00) `CHECK("outputs", sel2, {motorOutB, motorOutA})
         readExp(8'h00, ctrl);
      end
      mdr_host_model_inst.wr(8'h02, 8'hFF);
      readExp(8'h02, 8'h00);
      readExp(8'h00, ctrl);
      $display("bridge test done");
      // Each fault source in turn, then a clear that also pokes every other bit.
      mdr_host_model_inst.wr(8'h00, 8'h01);
      repeat (WAKE + 6) @(negedge ref_clk);
      for (int i = 0; i < 4; i++) begin
         // Move the address pins with the undervoltage onset so the recapture shows.
         if (i == 2) addrPinCode = 4'($unsigned($random(seed)) % 9);
         faultPins[i] = 1'b1;
         repeat (HOLD + 8) @(negedge ref_clk);
         faultPins = 4'h0;
         repeat (4) @(negedge ref_clk);
         `CHECK("error pin", 1'b0, errorPinOeN)
         `CHECK("bridge off", i == 0 || i == 3, motorOutAOeN)
         if (i == 2) `CHECK("address again", 7'h60 + 7'(addrPinCode), slaveAddr)
         readExp(8'h01, expFault[i]);
         mdr_host_model_inst.wr(8'h01, 8'hFF);
         readExp(8'h01, 8'h00);
         repeat (4) @(negedge ref_clk);
         `CHECK("bridge back", 1'b0, motorOutAOeN)
      end
      $display("fault test done");
      mdr_host_model_inst.park();
      for (int k = 0; k < 20 && expQ.size() != 0; k++) @(negedge ref_clk);
      `CHECK("answers left", 0, expQ.size())
      stopTest();
   end
endmodule : mdr_regs_tb
